// >>> core/sik_top.sv
// Interrupt enable/status registers and key-store check status for the serializer.
// Assumes a register access port from the serial control bus engine on REF_CLK,
// and a key-check engine and indirect-access engine on the same clock.
`timescale 1ns/100ps
`include "sik_map.svh"
module sik_top
  import sik_pkg::*;
(
  // Clock and reset
  input wire logic REF_CLK,
  input wire logic SRST,
  // Register access port
  input wire logic [7:0] REG_ADDR,
  input wire logic REG_WR,
  input wire logic REG_RD,
  input wire logic [7:0] REG_WDATA,
  output logic [7:0] REG_RDATA,
  // Interrupt sources
  input wire logic INDIRECT_DONE,
  input wire logic RX_DETECT,
  input wire logic RX_LOCK,
  input wire logic RX_IRQ,
  input wire logic RECEIVER_FOUND_NEEDS_LOCK,
  // Interrupt to the local controller
  output logic IRQ_OUT,
  // Key-check engine
  output logic KEY_CHECK_GO,
  input wire logic KEY_CHECK_DONE,
  input wire logic KEY_CHECK_OK
);
  // ----------------------------------------
  // Pin synchronisation
  // ----------------------------------------
  logic [2:0] pins_s;
  logic det_s;
  logic lock_s;
  logic rxirq_s;

  sik_sync #(.W(3)) u_sync (
    .clk(REF_CLK),
    .srst(SRST),
    .d({RX_DETECT, RX_LOCK, RX_IRQ}),
    .q(pins_s)
  );
  assign det_s = pins_s[2];
  assign lock_s = pins_s[1];
  assign rxirq_s = pins_s[0];

  // ----------------------------------------
  // Decode
  // ----------------------------------------
  logic wr_en;
  logic wr_key;
  logic rd_stat;
  assign wr_en = REG_WR && (REG_ADDR == `SIK_OFS_IRQ_ENABLE);
  assign wr_key = REG_WR && (REG_ADDR == `SIK_OFS_KEY_CHECK);
  assign rd_stat = REG_RD && (REG_ADDR == `SIK_OFS_IRQ_STATUS);

  // ----------------------------------------
  // Enable register
  // ----------------------------------------
  logic [7:0] irq_enable_r;

  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      irq_enable_r <= `SIK_RST_IRQ_ENABLE;
    end else if (wr_en) begin
      irq_enable_r <= REG_WDATA & `SIK_ENABLE_MASK;
    end
  end

  // ----------------------------------------
  // Source flags
  // ----------------------------------------
  logic indirect_done_flag_r;
  logic receiver_found_flag_r;
  logic downstream_irq_flag_r;
  logic global_flag;

  // Completion is a pulse, so it is held until software reads status; set wins
  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      indirect_done_flag_r <= 1'b0;
    end else if (INDIRECT_DONE) begin
      indirect_done_flag_r <= 1'b1;
    end else if (rd_stat) begin
      indirect_done_flag_r <= 1'b0;
    end
  end

  // Receiver detect and forwarded requests are levels and track their source
  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      receiver_found_flag_r <= 1'b0;
      downstream_irq_flag_r <= 1'b0;
    end else begin
      receiver_found_flag_r <= det_s && (!RECEIVER_FOUND_NEEDS_LOCK || lock_s);
      downstream_irq_flag_r <= rxirq_s;
    end
  end

  assign global_flag = (indirect_done_flag_r && irq_enable_r[`SIK_BIT_INDIRECT])
    || (receiver_found_flag_r && irq_enable_r[`SIK_BIT_RXFOUND])
    || (downstream_irq_flag_r && irq_enable_r[`SIK_BIT_DOWNSTREAM]);

  logic [7:0] irq_status;
  always_comb begin
    irq_status = `SIK_RST_IRQ_STATUS;
    irq_status[`SIK_BIT_INDIRECT] = indirect_done_flag_r;
    irq_status[`SIK_BIT_RXFOUND] = receiver_found_flag_r;
    irq_status[`SIK_BIT_DOWNSTREAM] = downstream_irq_flag_r;
    irq_status[`SIK_BIT_GLOBAL] = global_flag;
  end

  // ----------------------------------------
  // Interrupt output
  // ----------------------------------------
  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      IRQ_OUT <= 1'b0;
    end else begin
      IRQ_OUT <= global_flag && irq_enable_r[`SIK_BIT_GLOBAL];
    end
  end

  // ----------------------------------------
  // Key-store check
  // ----------------------------------------
  sik_chk_state_t chk_state_r;
  logic key_check_passed_r;
  logic key_check_finished_r;
  logic [7:0] key_spare_r;
  logic start_req;
  assign start_req = wr_key && REG_WDATA[`SIK_BIT_START] && (chk_state_r == CHK_IDLE);

  // A start while busy is ignored; the running check is not restarted
  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      chk_state_r <= CHK_IDLE;
    end else begin
      unique case (chk_state_r)
        CHK_IDLE: begin
          if (start_req) begin
            chk_state_r <= CHK_BUSY;
          end
        end
        CHK_BUSY: begin
          if (KEY_CHECK_DONE) begin
            chk_state_r <= CHK_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      KEY_CHECK_GO <= 1'b0;
    end else begin
      KEY_CHECK_GO <= start_req;
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      key_check_finished_r <= 1'b0;
      key_check_passed_r <= 1'b0;
    end else if (chk_state_r == CHK_BUSY && KEY_CHECK_DONE) begin
      key_check_finished_r <= 1'b1;
      key_check_passed_r <= KEY_CHECK_OK;
    end else if (start_req) begin
      key_check_finished_r <= 1'b0;
      key_check_passed_r <= 1'b0;
    end
  end

  // Reserved RW bits simply hold what software wrote
  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      key_spare_r <= `SIK_RST_KEY_CHECK;
    end else if (wr_key) begin
      key_spare_r <= REG_WDATA & `SIK_KEY_RW_MASK;
    end
  end

  logic [7:0] key_ctl;
  always_comb begin
    key_ctl = key_spare_r;
    key_ctl[`SIK_BIT_PASSED] = key_check_passed_r;
    key_ctl[`SIK_BIT_FINISHED] = key_check_finished_r;
    key_ctl[`SIK_BIT_START] = (chk_state_r == CHK_BUSY);
  end

  // ----------------------------------------
  // Read data
  // ----------------------------------------
  // One cycle read latency; unmapped offsets read zero
  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      REG_RDATA <= 8'h00;
    end else if (REG_RD) begin
      unique case (REG_ADDR)
        `SIK_OFS_IRQ_ENABLE: REG_RDATA <= irq_enable_r;
        `SIK_OFS_IRQ_STATUS: REG_RDATA <= irq_status;
        `SIK_OFS_KEY_CHECK: REG_RDATA <= key_ctl;
        default: REG_RDATA <= 8'h00;
      endcase
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (SRST);

  indirect_gate_a: assert property (
    !irq_enable_r[`SIK_BIT_INDIRECT] && !receiver_found_flag_r && !downstream_irq_flag_r
    |-> !global_flag) else $error("indirect flag leaks while disabled");
  rxfound_gate_a: assert property (
    irq_enable_r[`SIK_BIT_RXFOUND] && receiver_found_flag_r |-> global_flag)
    else $error("receiver found not reported");
  downstream_gate_a: assert property (
    irq_enable_r[`SIK_BIT_DOWNSTREAM] && downstream_irq_flag_r && irq_enable_r[0]
    |=> IRQ_OUT) else $error("forwarded request not propagated");
  master_gate_a: assert property (
    IRQ_OUT |-> $past(irq_enable_r[`SIK_BIT_GLOBAL]) && $past(global_flag))
    else $error("interrupt without master enable");
  indirect_sticky_a: assert property (
    INDIRECT_DONE |=> indirect_done_flag_r) else $error("completion lost");
  status_read_a: assert property (
    rd_stat |=> REG_RDATA[6] == $past(receiver_found_flag_r) && REG_RDATA[4:1] == 4'h0)
    else $error("status read wrong");
  rxirq_track_a: assert property (
    $rose(rxirq_s) |=> downstream_irq_flag_r) else $error("forwarded flag missed");
  lock_needed_a: assert property (
    RECEIVER_FOUND_NEEDS_LOCK && !lock_s |=> !receiver_found_flag_r)
    else $error("detect without lock");
  check_result_a: assert property (
    chk_state_r == CHK_BUSY && KEY_CHECK_DONE
    |=> key_check_finished_r && key_check_passed_r == $past(KEY_CHECK_OK))
    else $error("key check result wrong");
  check_start_a: assert property (
    start_req |=> KEY_CHECK_GO && chk_state_r == CHK_BUSY && !key_check_finished_r)
    else $error("key check did not start");
  finished_hold_a: assert property (
    key_check_finished_r && !start_req |=> key_check_finished_r)
    else $error("finished flag dropped");
  enable_mask_a: assert property (
    wr_en |=> (irq_enable_r & 8'h1e) == 8'h00) else $error("reserved enable bit stored");

  irq_raised_c: cover property ($rose(IRQ_OUT));
  check_pass_c: cover property ($rose(key_check_finished_r) && key_check_passed_r);
  clear_race_c: cover property (INDIRECT_DONE && rd_stat);
endmodule

// >>> core/sik_map.svh
// Register offsets, field positions, reset values and timing for the interrupt block.
// Assumes inclusion by bare name from files that sit in core/.
//
// What this block does
// - Enable bit 7 lets a finished indirect register access raise the interrupt.
// - Enable bit 6 lets receiver detection raise the interrupt.
// - Enable bit 5 lets a request forwarded by the downstream receiver raise the interrupt.
// - Enable bit 0 is the master gate; the interrupt output is driven only while it is set.
// - Status bit 7 reports that an indirect register access has completed.
// - Status bit 6 reports that a downstream receiver has been detected.
// - Status bit 5 reports that the downstream receiver has forwarded an interrupt request.
// - Status bit 0 is the OR of every source flag whose enable bit is set.
// - Key-check bit 7 gives the result, 1 passed and 0 failed, valid only while bit 6 is set.
// - Key-check bit 6 is a read-only flag set when verification has finished.
// - Writing 1 to key-check bit 2 starts verification and the device clears it when done.
// - Receiver detection alone raises its source when lock is not required, else lock too.
`ifndef SIK_MAP_SVH
`define SIK_MAP_SVH

// ----------------------------------------
// Offsets
// ----------------------------------------
`define SIK_OFS_IRQ_ENABLE 8'hc6
`define SIK_OFS_IRQ_STATUS 8'hc7
`define SIK_OFS_KEY_CHECK 8'hc8

// ----------------------------------------
// Field positions
// ----------------------------------------
`define SIK_BIT_INDIRECT 7
`define SIK_BIT_RXFOUND 6
`define SIK_BIT_DOWNSTREAM 5
`define SIK_BIT_GLOBAL 0
`define SIK_BIT_PASSED 7
`define SIK_BIT_FINISHED 6
`define SIK_BIT_START 2
`define SIK_ENABLE_MASK 8'he1
`define SIK_KEY_RW_MASK 8'h23

// ----------------------------------------
// Reset values
// ----------------------------------------
`define SIK_RST_IRQ_ENABLE 8'h00
`define SIK_RST_IRQ_STATUS 8'h00
`define SIK_RST_KEY_CHECK 8'h00

// ----------------------------------------
// Timing
// ----------------------------------------
`define SIK_SYNC_STAGES 2

`endif

// >>> core/sik_pkg.sv
// Types shared by the interrupt and key-check block.
// Assumes sik_map.svh is available for constants.
package sik_pkg;
  typedef enum logic [0:0] {CHK_IDLE, CHK_BUSY} sik_chk_state_t;
endpackage

// >>> core/sik_sync.sv
// Two flip-flop synchroniser for pin inputs.
// Assumes the inputs are quasi-static levels from outside the REF_CLK domain.
`timescale 1ns/100ps
`include "sik_map.svh"
module sik_sync
  import sik_pkg::*;
#(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Data
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_r;

  // First stage is read only by the second stage
  always_ff @(posedge clk) begin
    if (srst) begin
      meta_r <= '0;
      q <= '0;
    end else begin
      meta_r <= d;
      q <= meta_r;
    end
  end
endmodule

// >>> bench/sik_far_model.sv
// Behavioural key-check engine that faces the block's start and finish handshake.
// Assumes the start pulse arrives on the same clock and the delay stays above zero.
`timescale 1ns/100ps
module sik_far_model (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Engine handshake
  input wire logic go,
  input wire logic [7:0] dly,
  input wire logic ok_in,
  output logic done,
  output logic ok
);
  // ----------------------------------------
  // Engine
  // ----------------------------------------
  logic [7:0] cnt_r;
  logic busy_r;

  // Result is shown only with the finish pulse; otherwise it is inverted so nothing leans on it
  always_ff @(posedge clk) begin
    if (srst) begin
      busy_r <= 1'b0;
      cnt_r <= 8'h00;
      done <= 1'b0;
      ok <= 1'b0;
    end else if (!busy_r) begin
      done <= 1'b0;
      ok <= ~ok_in;
      if (go) begin
        busy_r <= 1'b1;
        cnt_r <= dly;
      end
    end else if (cnt_r <= 8'h01) begin
      busy_r <= 1'b0;
      done <= 1'b1;
      ok <= ok_in;
    end else begin
      cnt_r <= cnt_r - 8'h01;
    end
  end
endmodule

// >>> bench/sik_top_bench.sv
// Self-checking bench for the interrupt and key-check block.
// Assumes the design files under core/ and the key-check engine model.
`timescale 1ns/100ps
module sik_top_bench;
  // ----------------------------------------
  // Signals and instances
  // ----------------------------------------
  logic REF_CLK = 1'b0, SRST = 1'b1, REG_WR = 1'b0, REG_RD = 1'b0;
  logic [7:0] REG_ADDR = 8'h00, REG_WDATA = 8'h00, REG_RDATA, m, dly = 8'h08;
  logic INDIRECT_DONE = 1'b0, RX_DETECT = 1'b0, RX_LOCK = 1'b0, RX_IRQ = 1'b0;
  logic RECEIVER_FOUND_NEEDS_LOCK = 1'b0, ok_in = 1'b1;
  logic IRQ_OUT, KEY_CHECK_GO, KEY_CHECK_DONE, KEY_CHECK_OK;
  int failures = 0, checks = 0, i, n;

  always #50 REF_CLK = ~REF_CLK;

  sik_top uut (.REF_CLK(REF_CLK), .SRST(SRST), .REG_ADDR(REG_ADDR), .REG_WR(REG_WR),
    .REG_RD(REG_RD), .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA),
    .INDIRECT_DONE(INDIRECT_DONE), .RX_DETECT(RX_DETECT), .RX_LOCK(RX_LOCK), .RX_IRQ(RX_IRQ),
    .RECEIVER_FOUND_NEEDS_LOCK(RECEIVER_FOUND_NEEDS_LOCK), .IRQ_OUT(IRQ_OUT),
    .KEY_CHECK_GO(KEY_CHECK_GO), .KEY_CHECK_DONE(KEY_CHECK_DONE), .KEY_CHECK_OK(KEY_CHECK_OK));

  sik_far_model far (.clk(REF_CLK), .srst(SRST), .go(KEY_CHECK_GO), .dly(dly), .ok_in(ok_in),
    .done(KEY_CHECK_DONE), .ok(KEY_CHECK_OK));

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task results;
    if (failures == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task cmp(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge REF_CLK);
    REG_ADDR <= a;
    REG_WDATA <= d;
    REG_WR <= 1'b1;
    @(posedge REF_CLK);
    REG_WR <= 1'b0;
    #1;
  endtask

  // Read data lands at the edge after the strobe edge
  task chk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge REF_CLK);
    REG_ADDR <= a;
    REG_RD <= 1'b1;
    @(posedge REF_CLK);
    REG_RD <= 1'b0;
    #1;
    cmp(REG_RDATA, exp);
  endtask

  // Indirect completion is a one-cycle pulse, the pin sources are levels
  task fire(input int s, input logic v);
    @(posedge REF_CLK);
    case (s)
      0: INDIRECT_DONE <= v;
      1: RX_DETECT <= v;
      default: RX_IRQ <= v;
    endcase
    if (s == 0 && v) begin
      @(posedge REF_CLK);
      INDIRECT_DONE <= 1'b0;
    end
  endtask

  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial begin
    repeat (2) @(posedge REF_CLK);
    SRST <= 1'b0;
    chk(8'hc6, 8'h00);
    chk(8'hc7, 8'h00);
    chk(8'hc8, 8'h00);
    chk(8'h10, 8'h00);
    wr(8'hc6, 8'hff);
    chk(8'hc6, 8'he1);
    wr(8'hc7, 8'hff);
    chk(8'hc7, 8'h00);
    for (i = 0; i < 3; i++) begin
      m = 8'h80 >> i;
      wr(8'hc6, m | 8'h01);
      fire(i, 1'b1);
      repeat (5) @(posedge REF_CLK);
      #1;
      cmp({7'h00, IRQ_OUT}, 8'h01);
      chk(8'hc7, m | 8'h01);
      wr(8'hc6, 8'h01);
      fire(i, 1'b1);
      repeat (5) @(posedge REF_CLK);
      #1;
      cmp({7'h00, IRQ_OUT}, 8'h00);
      chk(8'hc7, m);
      wr(8'hc6, m);
      fire(i, 1'b1);
      repeat (5) @(posedge REF_CLK);
      #1;
      cmp({7'h00, IRQ_OUT}, 8'h00);
      chk(8'hc7, m | 8'h01);
      fire(i, 1'b0);
      repeat (5) @(posedge REF_CLK);
    end
    chk(8'hc7, 8'h00);
    // A completion in the very cycle of a status read must survive the read
    @(posedge REF_CLK);
    REG_ADDR <= 8'hc7;
    REG_RD <= 1'b1;
    INDIRECT_DONE <= 1'b1;
    @(posedge REF_CLK);
    REG_RD <= 1'b0;
    INDIRECT_DONE <= 1'b0;
    #1;
    cmp(REG_RDATA, 8'h00);
    chk(8'hc7, 8'h80);
    // Detection without lock must stay hidden once lock is required
    wr(8'hc6, 8'h00);
    @(posedge REF_CLK);
    RECEIVER_FOUND_NEEDS_LOCK <= 1'b1;
    RX_DETECT <= 1'b1;
    repeat (5) @(posedge REF_CLK);
    chk(8'hc7, 8'h00);
    @(posedge REF_CLK);
    RX_LOCK <= 1'b1;
    repeat (5) @(posedge REF_CLK);
    chk(8'hc7, 8'h40);
    // Prompt pass, then slow fail
    for (n = 0; n < 2; n++) begin
      @(posedge REF_CLK);
      dly <= (n == 0) ? 8'h08 : 8'h1e;
      ok_in <= (n == 0);
      wr(8'hc8, 8'h04);
      cmp({7'h00, KEY_CHECK_GO}, 8'h01);
      chk(8'hc8, 8'h04);
      for (i = 0; i < 100 && KEY_CHECK_DONE !== 1'b1; i++) begin
        @(posedge REF_CLK);
        #1;
      end
      if (i == 100) begin
        failures++;
        $display("mismatch at %0t: key check never finished", $time);
        n = 2;
      end else begin
        repeat (2) @(posedge REF_CLK);
        chk(8'hc8, (n == 0) ? 8'hc0 : 8'h40);
      end
    end
    results;
  end
endmodule
